// ### verilog/panel_defines.svh
// Purpose: constants for the front panel switch and indicator logic
// Assumes: 10 MHz system clock
// Notes: debounce and reset-stretch times are given in microseconds
`ifndef PANEL_DEFINES_SVH
`define PANEL_DEFINES_SVH
`define CLK_PERIOD_NS 100
`define DEBOUNCE_US 10000
`define DEBOUNCE_CYC ((`DEBOUNCE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_HOLD_US 200
`define RESET_HOLD_CYC ((`RESET_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 20
`define LED_COUNT 6
`define LED_CHECKSTOP 0
`define LED_BOARD_FAULT 1
`define LED_CPU_ACT 2
`define LED_PCI_ACT 3
`define LED_SUPPLY_GOOD 4
`define LED_SYS_CTRL 5
`endif

// ### verilog/panel_pkg.sv
// Purpose: types for the front panel switch and indicator logic
// Assumes: panel_defines.svh gives the widths
// Notes: state is carried as one packed struct
`include "panel_defines.svh"
package panel_pkg;
  typedef enum logic [2:0] {
    DB_IDLE = 3'b001,
    DB_PRESSED = 3'b010,
    DB_RELEASE = 3'b100
  } db_state_t;

  typedef struct packed {
    logic checkstop;
    logic board_fault;
    logic cpu_busy;
    logic pci_busy;
    logic supply_5v;
    logic supply_p12v;
    logic supply_n12v;
  } board_status_t;

  typedef struct packed {
    logic watchdog_timeout;
    logic bridge_misc_control;
  } reset_req_t;

  typedef struct packed {
    db_state_t abort_st;
    logic [`CNT_W-1:0] abort_cnt;
    logic abort_irq;
    db_state_t reset_st;
    logic [`CNT_W-1:0] reset_cnt;
    logic [`CNT_W-1:0] hold_cnt;
    logic board_reset;
    logic sysreset_drive;
    logic [`LED_COUNT-1:0] leds;
  } panel_state_t;
endpackage : panel_pkg

// ### verilog/front_panel_switch_led_logic.sv
// Purpose: debounced abort interrupt, reset pushbutton and power-up reset fan-out, indicator drive
// Assumes: button and status inputs are synchronous to clk_sys; buttons active high when pressed
// Notes: SYSRESET* is open-drain; its enable is low while driven
`timescale 1ns/1ps
`include "panel_defines.svh"

module front_panel_switch_led_logic #(
  parameter int unsigned DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter int unsigned RESET_HOLD_CYC = `RESET_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic abort_button,
  input wire logic reset_button,
  input wire logic sys_controller,
  input wire panel_pkg::board_status_t status,
  input wire panel_pkg::reset_req_t reset_req,
  input wire logic sysreset_in_n,
  output logic abort_irq,
  output logic board_reset,
  output logic sysreset_out,
  output logic sysreset_oe_n,
  output logic [`LED_COUNT-1:0] leds
);
  import panel_pkg::*;

  localparam logic [`CNT_W-1:0] DB_LAST = `CNT_W'(DEBOUNCE_CYC - 1);
  localparam logic [`CNT_W-1:0] HOLD_LAST = `CNT_W'(RESET_HOLD_CYC - 1);

  panel_state_t s_r;
  panel_state_t s_nxt;
  logic sys_reset_src;
  logic hold_active;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.abort_irq = 1'b0;
    // Abort: accept a press only after it is steady, then wait for a steady release
    case (s_r.abort_st)
      DB_IDLE:
      begin
        if (abort_button)
        begin
          if (s_r.abort_cnt == DB_LAST)
          begin
            s_nxt.abort_st = DB_PRESSED;
            s_nxt.abort_cnt = '0;
            s_nxt.abort_irq = 1'b1;
          end
          else
            s_nxt.abort_cnt = s_r.abort_cnt + 1'b1;
        end
        else
          s_nxt.abort_cnt = '0;
      end
      DB_PRESSED:
      begin
        if (!abort_button)
        begin
          if (s_r.abort_cnt == DB_LAST)
          begin
            s_nxt.abort_st = DB_IDLE;
            s_nxt.abort_cnt = '0;
          end
          else
            s_nxt.abort_cnt = s_r.abort_cnt + 1'b1;
        end
        else
          s_nxt.abort_cnt = '0;
      end
      default:
      begin
        s_nxt.abort_st = DB_IDLE;
        s_nxt.abort_cnt = '0;
      end
    endcase

    // Reset button: debounce the press; hold reset while pressed and a while after
    case (s_r.reset_st)
      DB_IDLE:
      begin
        if (reset_button)
        begin
          if (s_r.reset_cnt == DB_LAST)
          begin
            s_nxt.reset_st = DB_PRESSED;
            s_nxt.reset_cnt = '0;
          end
          else
            s_nxt.reset_cnt = s_r.reset_cnt + 1'b1;
        end
        else
          s_nxt.reset_cnt = '0;
      end
      DB_PRESSED:
      begin
        if (!reset_button)
        begin
          if (s_r.reset_cnt == DB_LAST)
          begin
            s_nxt.reset_st = DB_IDLE;
            s_nxt.reset_cnt = '0;
          end
          else
            s_nxt.reset_cnt = s_r.reset_cnt + 1'b1;
        end
        else
          s_nxt.reset_cnt = '0;
      end
      default:
      begin
        s_nxt.reset_st = DB_IDLE;
        s_nxt.reset_cnt = '0;
      end
    endcase

    if (s_nxt.reset_st == DB_PRESSED)
      s_nxt.hold_cnt = '0;
    else if (s_r.hold_cnt != HOLD_LAST)
      s_nxt.hold_cnt = s_r.hold_cnt + 1'b1;

    hold_active = (s_nxt.reset_st == DB_PRESSED) || (s_nxt.hold_cnt != HOLD_LAST);
    // Power-up hold counts from reset release, so it covers the power-up source too
    sys_reset_src = hold_active || reset_req.watchdog_timeout || reset_req.bridge_misc_control;
    s_nxt.board_reset = hold_active;
    s_nxt.sysreset_drive = sys_controller && sys_reset_src;

    // Lamp test overrides the status indicators while board reset is in force
    if (hold_active)
      s_nxt.leds = '1;
    else
    begin
      s_nxt.leds[`LED_CHECKSTOP] = status.checkstop;
      s_nxt.leds[`LED_BOARD_FAULT] = status.board_fault;
      s_nxt.leds[`LED_CPU_ACT] = status.cpu_busy;
      s_nxt.leds[`LED_PCI_ACT] = status.pci_busy;
      s_nxt.leds[`LED_SUPPLY_GOOD] = status.supply_5v && status.supply_p12v && status.supply_n12v;
      s_nxt.leds[`LED_SYS_CTRL] = sys_controller;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_r.abort_st <= DB_IDLE;
      s_r.abort_cnt <= '0;
      s_r.abort_irq <= 1'b0;
      s_r.reset_st <= DB_IDLE;
      s_r.reset_cnt <= '0;
      s_r.hold_cnt <= '0;
      s_r.board_reset <= 1'b1;
      s_r.sysreset_drive <= 1'b0;
      s_r.leds <= '1;
    end
    else
      s_r <= s_nxt;
  end

  assign abort_irq = s_r.abort_irq;
  assign board_reset = s_r.board_reset;
  assign sysreset_out = 1'b0;
  assign sysreset_oe_n = ~s_r.sysreset_drive;
  assign leds = s_r.leds;

  // Interrupt is high for exactly one cycle
  sequence irq_pulse;
    abort_irq ##1 !abort_irq;
  endsequence

  a_abort_single_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    abort_irq |-> irq_pulse)
    else $error("abort interrupt longer than one cycle");
  a_abort_needs_press: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(abort_irq) |-> $past(abort_button))
    else $error("abort interrupt without press");
  a_reset_on_button: assert property (@(posedge clk_sys) disable iff (rst)
    (s_r.reset_st == DB_PRESSED) |=> board_reset)
    else $error("board reset missing during press");
  a_sysreset_gated: assert property (@(posedge clk_sys) disable iff (rst)
    !sysreset_oe_n |-> $past(sys_controller))
    else $error("SYSRESET driven when not system controller");
  a_sysreset_sources: assert property (@(posedge clk_sys) disable iff (rst)
    ($past(sys_controller) && $past(reset_req.watchdog_timeout)) |-> !sysreset_oe_n)
    else $error("watchdog did not drive SYSRESET");
  a_lamp_test: assert property (@(posedge clk_sys) disable iff (rst)
    board_reset |-> (leds == '1))
    else $error("lamp test not lit during reset");
  a_supply_led: assert property (@(posedge clk_sys) disable iff (rst)
    (!board_reset && leds[`LED_SUPPLY_GOOD]) |->
      ($past(status.supply_5v) && $past(status.supply_p12v) && $past(status.supply_n12v)))
    else $error("supply good lit without all supplies");
  a_sysctl_led: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(hold_active) |-> (leds[`LED_SYS_CTRL] == $past(sys_controller)))
    else $error("system controller indicator wrong");
  a_checkstop_led: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(hold_active) |-> (leds[`LED_CHECKSTOP] == $past(status.checkstop)))
    else $error("checkstop indicator wrong");
  a_press_no_irq_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (s_r.abort_st == DB_PRESSED) |=> !abort_irq)
    else $error("second interrupt within one press");
  a_fault_led: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(hold_active) |-> (leds[`LED_BOARD_FAULT] == $past(status.board_fault)))
    else $error("board fault indicator wrong");
  a_cpu_led: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(hold_active) |-> (leds[`LED_CPU_ACT] == $past(status.cpu_busy)))
    else $error("processor activity indicator wrong");
  a_pci_led: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(hold_active) |-> (leds[`LED_PCI_ACT] == $past(status.pci_busy)))
    else $error("PCI activity indicator wrong");
  a_sysctl_agree: assert property (@(posedge clk_sys) disable iff (rst)
    !sysreset_oe_n |-> leds[`LED_SYS_CTRL])
    else $error("SYSRESET driven while system controller indicator dark");
endmodule : front_panel_switch_led_logic

// ### dv/panel_button_model.sv
// Purpose: model of the front panel pushbuttons and the processor interrupt input
// Assumes: buttons change just after a rising clk_sys edge
// Notes: every button change starts with a short bounce train
`timescale 1ns/1ps
module panel_button_model (
  input wire logic clk_sys,
  input wire logic abort_irq,
  output logic abort_button,
  output logic reset_button
);
  int irq_count = 0;
  initial
  begin
    abort_button = 1'b0;
    reset_button = 1'b0;
  end
  // Processor side counts each interrupt pulse
  always @(posedge clk_sys) if (abort_irq === 1'b1) irq_count <= irq_count + 1;
  // Bounce of single-cycle pulses, then the steady level
  task automatic set(input bit rst_btn, input bit level);
    logic v;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_sys);
      v = i[0] ? level : ~level;
      if (rst_btn) reset_button <= v;
      else abort_button <= v;
    end
  endtask : set
endmodule : panel_button_model

// ### dv/front_panel_switch_led_logic_tb.sv
// Purpose: self-checking bench for the front panel logic
// Assumes: short debounce and hold counts
// Notes: expectations come from a bench model of the indicators and resets
`timescale 1ns/1ps
module front_panel_switch_led_logic_tb;
  import panel_pkg::*;
  logic clk_sys, rst, sys_controller, abort_button, reset_button, sysreset_in_n;
  board_status_t status;
  reset_req_t reset_req;
  logic abort_irq, board_reset, sysreset_out, sysreset_oe_n;
  logic [5:0] leds;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  assign sysreset_in_n = sysreset_oe_n ? 1'b1 : sysreset_out;
  front_panel_switch_led_logic #(.DEBOUNCE_CYC(4), .RESET_HOLD_CYC(3)) front_panel_switch_led_logic_inst (
    .clk_sys(clk_sys), .rst(rst), .abort_button(abort_button), .reset_button(reset_button),
    .sys_controller(sys_controller), .status(status), .reset_req(reset_req), .sysreset_in_n(sysreset_in_n),
    .abort_irq(abort_irq), .board_reset(board_reset), .sysreset_out(sysreset_out),
    .sysreset_oe_n(sysreset_oe_n), .leds(leds));
  panel_button_model panel_button_model_inst (.clk_sys(clk_sys), .abort_irq(abort_irq),
    .abort_button(abort_button), .reset_button(reset_button));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_leds(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t leds got %h exp %h", $time, got, exp);
    end
  endtask : chk_leds
  task automatic chk_int(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t interrupt count got %0d exp %0d", $time, got, exp);
    end
  endtask : chk_int
  function automatic logic [5:0] exp_leds(board_status_t s, logic c);
    return {c, s.supply_5v & s.supply_p12v & s.supply_n12v, s.pci_busy, s.cpu_busy, s.board_fault, s.checkstop};
  endfunction : exp_leds
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc >= 3000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(32'hea9d));
    rst = 1'b1;
    sys_controller = 1'b1;
    status = '0;
    reset_req = '0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk_leds(leds, 6'h3f);
    @(posedge clk_sys);
    #1 chk_bit(board_reset, 1'b1);
    chk_bit(sysreset_oe_n, 1'b0);
    chk_leds(leds, 6'h3f);
    repeat (8) @(posedge clk_sys);
    #1 chk_bit(board_reset, 1'b0);
    for (int k = 0; k < 12; k++)
    begin
      @(posedge clk_sys);
      status <= board_status_t'($urandom);
      sys_controller <= k[0];
      repeat (2) @(posedge clk_sys);
      #1 chk_leds(leds, exp_leds(status, sys_controller));
    end
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk_sys);
      sys_controller <= k[2];
      reset_req <= reset_req_t'(k[1:0]);
      repeat (2) @(posedge clk_sys);
      #1 chk_bit(sysreset_oe_n, !(k[2] && k[1:0] != 2'b00));
      chk_bit(sysreset_out, 1'b0);
      chk_bit(board_reset, 1'b0);
    end
    @(posedge clk_sys);
    reset_req <= '0;
    for (int k = 1; k < 3; k++)
    begin
      panel_button_model_inst.set(1'b0, 1'b1);
      repeat (8) @(posedge clk_sys);
      panel_button_model_inst.set(1'b0, 1'b0);
      repeat (8) @(posedge clk_sys);
      #1 chk_int(panel_button_model_inst.irq_count, k);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_sys);
      sys_controller <= k[0];
      panel_button_model_inst.set(1'b1, 1'b1);
      repeat (6) @(posedge clk_sys);
      #1 chk_bit(board_reset, 1'b1);
      chk_bit(sysreset_oe_n, !k[0]);
      chk_leds(leds, 6'h3f);
      panel_button_model_inst.set(1'b1, 1'b0);
      repeat (12) @(posedge clk_sys);
      #1 chk_bit(board_reset, 1'b0);
      chk_bit(sysreset_oe_n, 1'b1);
    end
    // Second reset in mid-run: lamp test and power-up stretch again
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk_bit(board_reset, 1'b1);
    chk_bit(sysreset_oe_n, 1'b1);
    chk_leds(leds, 6'h3f);
    @(posedge clk_sys);
    #1 chk_bit(board_reset, 1'b1);
    chk_bit(sysreset_oe_n, 1'b0);
    chk_leds(leds, 6'h3f);
    repeat (4) @(posedge clk_sys);
    #1 chk_bit(board_reset, 1'b0);
    chk_leds(leds, exp_leds(status, sys_controller));
    end_sim();
  end
endmodule : front_panel_switch_led_logic_tb
